// >>> design/card_slot_host_control.sv
// serial register access, presence, shutdown and interrupt control
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - serial slave runs at link clock rates up to 400 kHz.
// - transfer is start, address byte with ack, one data byte, stop.
// - device acks address on ninth pulse; host data ack on reads ignored.
// - bank register always reachable, holds slot select; 1 to 5 routes.
// - second address target picked by two-bit pointer in slot main register.
// - slot main write register cannot be read back.
// - address select pin picks the serial address set.
// - pending event drives irq_out_n low; host reads causes.
// - early answer and no answer flags raised per slot.
// - overload kills its slot, overheat kills all; protection flag raised.
// - supply drop raises flag in every slot and kills every slot.
// - presence change flag only for slots 1 and 2; extraction deactivates.
// - aux falling edge sets general bit 5 until aux input releases.
// - in shutdown only slot 1 presence watched; interrupt raised at once.
// - shutdown exit resets registers, sets supply flags, general 1Fh or 3Fh.
// - edge speed register sets clock and data edges, resets to 44h.
// - slot 1 has own edge speed; slots 2 to 5 share one.
// - slot 1 presence polarity from strap; open input reads low.
// - slot 2 polarity follows strap, inverted when invert bit set.
// - slots 3 to 5 copy status input into presence bit only.
// - insertion confirmed when debounce counter reaches about 15 ms.
// - extraction not debounced; deactivation at first inactive edge.
// - no answer flag cleared when host reads it.
module card_slot_host_control
    import card_slot_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = card_slot_pkg::DEBOUNCE_CYC
) (
    // core clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // serial link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic address_select_pin_in,
    // interrupt and power
    output logic irq_out_n,
    input wire logic aux_irq_in_n,
    input wire logic shutdown_n_pin_in,
    // presence
    input wire logic presence_polarity_strap_in,
    input wire logic presence_slot1_in,
    input wire logic presence_slot2_in,
    input wire logic [2:0] sam_status_in,
    // slot events and control
    input wire card_slot_pkg::slot_events_t slot_events_in,
    input wire logic overheat_in,
    input wire logic supply_drop_in,
    output logic [card_slot_pkg::NUM_SLOTS-1:0] slot_active_out,
    output logic [7:0] slot1_edge_speed_out,
    output logic [7:0] shared_edge_speed_out
);
    import card_slot_pkg::*;

    localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);
    localparam int SW = 30;

    // core-side state
    logic [SW-1:0] sync1_q, sync2_q;
    logic [5:0] prev_q;
    logic in_frame_q, frame_clr_q, link_rst_q, irq_q;
    logic [2:0] slot_sel_q;
    logic inv2_q;
    logic [7:0] edge1_q, edge_sh_q, rd_byte_q;
    logic aux_flag_q;
    // link-side state
    logic [4:0] cnt_q;
    logic [7:0] sh_q, abyte_q, wdata_q;
    logic atgl_q, wtgl_q, match_q, rw_q, a0_1_q, a0_2_q, oe_q;

    // per-slot wires gathered from the generate loops
    logic [NUM_SLOTS-1:0] active_w, supply_drop_flag_w, nans_w, presence_change_flag_w, slot_presence_bit_bit_w, any_w, rd_stat_w;
    logic [7:0] status_w [NUM_SLOTS];
    logic [7:0] clkdiv_w [NUM_SLOTS];
    logic [1:0] ptr_w [NUM_SLOTS];
    logic [1:0] raw_w, slot_presence_bit_ok_w, deb_done_w, pevt_w, extract_w;

    // pin and toggle synchroniser input
    wire logic [SW-1:0] pins_w = {scl_in, sda_in, aux_irq_in_n, shutdown_n_pin_in,
        atgl_q, wtgl_q, address_select_pin_in, presence_polarity_strap_in,
        presence_slot1_in, presence_slot2_in, sam_status_in, overheat_in,
        supply_drop_in, slot_events_in};

    // two-flop synchronisers; second stage feeds all core-side logic
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_w;
            sync2_q <= sync1_q;
        end
    end

    // synchronised fields
    wire logic scl_s = sync2_q[29];
    wire logic sda_s = sync2_q[28];
    wire logic aux_s = sync2_q[27];
    wire logic sd_s = sync2_q[26];
    wire logic atgl_s = sync2_q[25];
    wire logic wtgl_s = sync2_q[24];
    wire logic a0_s = sync2_q[23];
    wire logic strap_s = sync2_q[22];
    wire logic [1:0] slot_presence_bit_s = {sync2_q[20], sync2_q[21]}; // bit 0 is slot 1
    wire logic [2:0] sam_s = sync2_q[19:17];
    wire logic heat_s = sync2_q[16];
    wire logic drop_s = sync2_q[15];
    wire slot_events_t ev_s = sync2_q[14:0];

    // previous samples for edge detection
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            prev_q <= '0;
        end else begin
            prev_q <= sync2_q[29:24];
        end
    end

    // edges and frame markers, oversampled well above 400 kHz
    wire logic start_w = scl_s & prev_q[5] & prev_q[4] & !sda_s;
    wire logic stop_w = scl_s & prev_q[5] & !prev_q[4] & sda_s;
    wire logic aux_fall_w = prev_q[3] & !aux_s;
    wire logic sd_rise_w = !prev_q[2] & sd_s;
    wire logic clr_w = !reset_n_in | !sd_s;
    wire logic addr_evt_w = atgl_s ^ prev_q[1];
    wire logic wr_evt_w = wtgl_s ^ prev_q[0];

    // target decode of the captured address byte
    wire logic [6:0] base_s_w = a0_s ? BASE_HI : BASE_LO;
    wire logic [6:0] rel_w = abyte_q[7:1] - base_s_w;
    wire logic hit_main_w = rel_w == REL_MAIN;
    wire logic hit_sec_w = rel_w == REL_SEC;
    wire logic hit_bank_w = rel_w == REL_BANK;
    wire logic rd_evt_w = addr_evt_w & abyte_q[0];
    wire logic [2:0] sel_idx_w = slot_sel_q - SLOT1_SEL;
    wire logic sel_ok_w = slot_sel_q != 3'h0 && sel_idx_w < 3'(NUM_SLOTS);
    wire logic [2:0] sec_idx_w = SEC_BASE + {1'b0, ptr_w[sel_idx_w]};
    wire logic [7:0] gen_int_w = {2'h0, aux_flag_q, any_w};

    // frame markers: counter cleared outside frames, released once scl low
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            in_frame_q <= 1'b0;
            frame_clr_q <= 1'b1;
            link_rst_q <= 1'b1;
        end else begin
            link_rst_q <= 1'b0;
            if (start_w) begin
                in_frame_q <= 1'b1;
                frame_clr_q <= 1'b1;
            end else if (stop_w) begin
                in_frame_q <= 1'b0;
                frame_clr_q <= 1'b1;
            end else if (in_frame_q && !scl_s) begin
                frame_clr_q <= 1'b0;
            end
        end
    end

    // address set from strap pin, synchronised on the link clock
    wire logic [6:0] rel_l_w = sh_q[6:0] - (a0_2_q ? BASE_HI : BASE_LO);
    wire logic link_hit_w = rel_l_w == REL_MAIN || rel_l_w == REL_SEC || rel_l_w == REL_BANK;

    // link shift and bit count; frame of one address and one data byte
    always_ff @(posedge scl_in or posedge frame_clr_q) begin
        if (frame_clr_q) begin
            cnt_q <= '0;
            sh_q <= '0;
            match_q <= 1'b0;
            rw_q <= 1'b0;
        end else begin
            sh_q <= {sh_q[6:0], sda_in};
            if (cnt_q != BIT_DONE) begin
                cnt_q <= cnt_q + 5'h01;
            end
            if (cnt_q == BIT_ADDR_LAST) begin
                match_q <= link_hit_w;
                rw_q <= sda_in;
            end
        end
    end

    // captured words cross by toggle; held until the next transfer
    always_ff @(posedge scl_in or posedge link_rst_q) begin
        if (link_rst_q) begin
            abyte_q <= '0;
            wdata_q <= '0;
            atgl_q <= 1'b0;
            wtgl_q <= 1'b0;
            a0_1_q <= 1'b0;
            a0_2_q <= 1'b0;
        end else begin
            a0_1_q <= address_select_pin_in;
            a0_2_q <= a0_1_q;
            if (cnt_q == BIT_ADDR_LAST && link_hit_w) begin
                abyte_q <= {sh_q[6:0], sda_in};
                atgl_q <= !atgl_q;
            end
            if (cnt_q == BIT_DATA_LAST && match_q && !rw_q) begin
                wdata_q <= {sh_q[6:0], sda_in};
                wtgl_q <= !wtgl_q;
            end
        end
    end

    // ack on ninth pulse of address; read data ack from host ignored
    wire logic ack_w = match_q && (cnt_q == BIT_ADDR_ACK || (cnt_q == BIT_DATA_ACK && !rw_q));
    wire logic [2:0] bit_idx_w = 3'(BIT_DATA_LAST - cnt_q);
    wire logic in_data_w = cnt_q >= BIT_DATA_FIRST && cnt_q <= BIT_DATA_LAST;
    wire logic rd_low_w = match_q && rw_q && in_data_w && !rd_byte_q[bit_idx_w];

    // sda changes only while scl low; rd_byte_q settled a full scl period before
    always_ff @(negedge scl_in or posedge frame_clr_q) begin
        if (frame_clr_q) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= ack_w | rd_low_w;
        end
    end

    // read data picked when the address byte arrives
    wire logic [7:0] rd_sec_w = sec_idx_w == CLKDIV_OFS ? clkdiv_w[sel_idx_w] :
        sec_idx_w == EDGE_SPEED_OFS ? (slot_sel_q == SLOT1_SEL ? edge1_q : edge_sh_q) : 8'h00;
    wire logic [7:0] rd_main_w = slot_sel_q == 3'h0 ? gen_int_w :
        sel_ok_w ? status_w[sel_idx_w] : 8'h00;
    wire logic [7:0] rd_mux_w = hit_bank_w ? {5'h00, slot_sel_q} :
        hit_main_w ? rd_main_w : (hit_sec_w && sel_ok_w) ? rd_sec_w : 8'h00;

    // read byte snapshot
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rd_byte_q <= '0;
        end else if (rd_evt_w) begin
            rd_byte_q <= rd_mux_w;
        end
    end

    // write strobes
    wire logic wr_bank_w = wr_evt_w & hit_bank_w;
    wire logic wr_main_w = wr_evt_w & hit_main_w & sel_ok_w;
    wire logic wr_sec_w = wr_evt_w & hit_sec_w & sel_ok_w;
    wire logic wr_edge_w = wr_sec_w & sec_idx_w == EDGE_SPEED_OFS;

    // bank register; edge speed copies; invert bit
    always_ff @(posedge clk_in) begin
        if (clr_w) begin
            slot_sel_q <= '0;
            inv2_q <= 1'b0;
            edge1_q <= EDGE_SPEED_RST;
            edge_sh_q <= EDGE_SPEED_RST;
        end else begin
            if (wr_bank_w) begin
                slot_sel_q <= wdata_q[2:0];
            end
            if (wr_main_w && sel_idx_w == 3'h1) begin
                inv2_q <= wdata_q[MAIN_INV];
            end
            if (wr_edge_w && slot_sel_q == SLOT1_SEL) begin
                edge1_q <= wdata_q;
            end
            if (wr_edge_w && slot_sel_q != SLOT1_SEL) begin
                edge_sh_q <= wdata_q;
            end
        end
    end

    // presence for slots 1 and 2; slot 2 idle in shutdown
    for (genvar p = 0; p < 2; p++) begin : g_slot_presence_bit
        logic [DW-1:0] deb_q;
        logic ok_q;
        wire logic inv_w = (p == 1) ? inv2_q : 1'b0;
        wire logic gate_w = (p == 0) ? 1'b1 : sd_s;
        assign raw_w[p] = (slot_presence_bit_s[p] ^ strap_s ^ inv_w) & gate_w;
        assign deb_done_w[p] = deb_q == DW'(DEBOUNCE_CYCLES - 1);
        assign slot_presence_bit_ok_w[p] = ok_q;
        assign extract_w[p] = ok_q & !raw_w[p];
        assign pevt_w[p] = (raw_w[p] & !ok_q & deb_done_w[p]) | extract_w[p];
        always_ff @(posedge clk_in) begin
            if (!reset_n_in || !raw_w[p]) begin
                deb_q <= '0;
                ok_q <= 1'b0;
            end else if (!ok_q && deb_done_w[p]) begin
                ok_q <= 1'b1;
            end else if (!ok_q) begin
                deb_q <= deb_q + DW'(1);
            end
        end
    end

    // per-slot flags and control
    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
        logic act_q, early_q, nans_q, protection_flag_q, supply_drop_flag_q, presence_change_flag_q;
        logic [1:0] ptr_q;
        logic [7:0] div_q;
        wire logic sel_w = sel_idx_w == 3'(i);
        wire logic rd_w = rd_evt_w & hit_main_w & sel_ok_w & sel_w;
        wire logic pev_w = (i < 2) ? pevt_w[i % 2] : 1'b0;
        wire logic ext_w = (i < 2) ? extract_w[i % 2] : 1'b0;
        wire logic ovl_w = sd_s & (ev_s.overload[i] | (heat_s & act_q));
        wire logic kill_w = (sd_s & drop_s) | ovl_w | ext_w;
        assign active_w[i] = act_q;
        assign supply_drop_flag_w[i] = supply_drop_flag_q;
        assign nans_w[i] = nans_q;
        assign presence_change_flag_w[i] = presence_change_flag_q;
        assign rd_stat_w[i] = rd_w;
        assign ptr_w[i] = ptr_q;
        assign clkdiv_w[i] = div_q;
        // slots 3 to 5 copy status pin only
        assign slot_presence_bit_bit_w[i] = (i < 2) ? slot_presence_bit_ok_w[i % 2] : sam_s[(i + 1) % 3];
        assign any_w[i] = early_q | nans_q | protection_flag_q | supply_drop_flag_q | presence_change_flag_q;
        always_comb begin
            status_w[i] = 8'h00;
            status_w[i][ST_SLOT_PRESENCE_BIT] = slot_presence_bit_bit_w[i];
            status_w[i][ST_EARLY] = early_q;
            status_w[i][ST_NANS] = nans_q;
            status_w[i][ST_PROTECTION_FLAG] = protection_flag_q;
            status_w[i][ST_SUPPLY_DROP_FLAG] = supply_drop_flag_q;
            status_w[i][ST_PRESENCE_CHANGE_FLAG] = presence_change_flag_q;
            status_w[i][ST_ACT] = act_q;
        end
        // pointer, start bit, divider; set wins over read clear
        always_ff @(posedge clk_in) begin
            if (clr_w) begin
                act_q <= 1'b0;
                ptr_q <= '0;
                div_q <= CLKDIV_RST;
                early_q <= 1'b0;
                nans_q <= 1'b0;
                protection_flag_q <= 1'b0;
            end else begin
                act_q <= (wr_main_w & sel_w ? wdata_q[MAIN_START] : act_q) & !kill_w;
                if (wr_main_w && sel_w) begin
                    ptr_q <= wdata_q[MAIN_PTR +: 2];
                end
                if (wr_sec_w && sel_w && sec_idx_w == CLKDIV_OFS) begin
                    div_q <= wdata_q;
                end
                early_q <= ev_s.early[i] | (early_q & !rd_w);
                nans_q <= ev_s.no_answer[i] | (nans_q & !rd_w);
                protection_flag_q <= ovl_w | (protection_flag_q & !rd_w);
            end
        end
        // supply flag, set in every slot on shutdown exit
        always_ff @(posedge clk_in) begin
            if (clr_w) begin
                supply_drop_flag_q <= 1'b0;
            end else begin
                supply_drop_flag_q <= sd_rise_w | drop_s | (supply_drop_flag_q & !rd_w);
            end
        end
        // presence change; slot 1 live during shutdown, all slots cleared at exit
        always_ff @(posedge clk_in) begin
            if (!reset_n_in || sd_rise_w || (i > 0 && !sd_s)) begin
                presence_change_flag_q <= 1'b0;
            end else begin
                presence_change_flag_q <= pev_w | (presence_change_flag_q & !rd_w);
            end
        end
    end

    // aux bit, held until the aux source lets go; caught at exit
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            aux_flag_q <= 1'b0;
        end else if ((aux_fall_w && sd_s) || (sd_rise_w && !aux_s)) begin
            aux_flag_q <= 1'b1;
        end else if (aux_s) begin
            aux_flag_q <= 1'b0;
        end
    end

    // interrupt low while any cause stands
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            irq_q <= 1'b1;
        end else begin
            irq_q <= !(|gen_int_w);
        end
    end

    // outputs
    assign irq_out_n = irq_q;
    assign sda_out = 1'b0;
    assign sda_oe_out = oe_q;
    assign slot_active_out = active_w;
    assign slot1_edge_speed_out = edge1_q;
    assign shared_edge_speed_out = edge_sh_q;

    // checks
    a_irq_on_event: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (|gen_int_w) |=> !irq_out_n) else $error("irq not asserted on pending cause");
    a_irq_release: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !(|gen_int_w) |=> irq_out_n) else $error("irq held with no cause");
    a_aux_sets_bit: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (aux_fall_w && sd_s) |=> gen_int_w[GEN_AUX_BIT]) else $error("aux edge lost");
    a_noans_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (rd_stat_w[0] && !ev_s.no_answer[0] && sd_s) |=> !nans_w[0])
        else $error("no answer flag survived read");
    a_supply_drop_all: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (drop_s && sd_s) |=> (active_w == '0 && supply_drop_flag_w == '1))
        else $error("supply drop did not reach all slots");
    a_overheat_all: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (heat_s && sd_s) |=> active_w == '0) else $error("overheat left a slot active");
    a_exit_loads: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        sd_rise_w |=> (gen_int_w[4:0] == '1 && gen_int_w[GEN_AUX_BIT] == !$past(aux_s))
        ##1 !irq_out_n) else $error("shutdown exit state wrong");
    a_extract_fast: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        extract_w[0] |=> (!slot_presence_bit_ok_w[0] && !active_w[0])) else $error("extraction slow");
    a_debounce_len: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(slot_presence_bit_ok_w[0]) |-> $past(deb_done_w[0])) else $error("insertion too early");
    a_sam_no_event: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        presence_change_flag_w[4:2] == '0) else $error("presence change on status-only slot");
    a_slot_select: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (wr_bank_w && sd_s) |=> slot_sel_q == $past(wdata_q[2:0]))
        else $error("slot select not stored");

endmodule
`default_nettype wire

// >>> design/card_slot_pkg.sv
// shared constants and types for the card slot host control block
package card_slot_pkg;

    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int I2C_MAX_HZ = 400_000;
    localparam int DEBOUNCE_MS = 15;
    localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;

    localparam int NUM_SLOTS = 5;

    // serial addresses, seven bits, relative to the strap-selected base
    localparam logic [6:0] BASE_LO = 7'h20;
    localparam logic [6:0] BASE_HI = 7'h22;
    localparam logic [6:0] REL_MAIN = 7'h00;
    localparam logic [6:0] REL_SEC = 7'h01;
    localparam logic [6:0] REL_BANK = 7'h04;

    // link bit counter positions
    localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
    localparam logic [4:0] BIT_ADDR_ACK = 5'h08;
    localparam logic [4:0] BIT_DATA_FIRST = 5'h09;
    localparam logic [4:0] BIT_DATA_LAST = 5'h10;
    localparam logic [4:0] BIT_DATA_ACK = 5'h11;
    localparam logic [4:0] BIT_DONE = 5'h12;

    // slot main write register fields
    localparam int MAIN_START = 0;
    localparam int MAIN_INV = 3;
    localparam int MAIN_PTR = 4;

    // slot status read fields
    localparam int ST_SLOT_PRESENCE_BIT = 0;
    localparam int ST_EARLY = 1;
    localparam int ST_NANS = 2;
    localparam int ST_PROTECTION_FLAG = 3;
    localparam int ST_SUPPLY_DROP_FLAG = 4;
    localparam int ST_PRESENCE_CHANGE_FLAG = 5;
    localparam int ST_ACT = 6;

    // secondary register index is base plus pointer
    localparam logic [2:0] SEC_BASE = 3'h4;
    localparam logic [2:0] CLKDIV_OFS = 3'h4;
    localparam logic [2:0] EDGE_SPEED_OFS = 3'h6;
    localparam logic [7:0] EDGE_SPEED_RST = 8'h44;
    localparam logic [7:0] CLKDIV_RST = 8'h00;

    localparam int GEN_AUX_BIT = 5;
    localparam logic [2:0] SLOT1_SEL = 3'h1;

    // per-slot event inputs from the card sequencers
    typedef struct packed {
        logic [NUM_SLOTS-1:0] early;
        logic [NUM_SLOTS-1:0] no_answer;
        logic [NUM_SLOTS-1:0] overload;
    } slot_events_t;

endpackage

// >>> sim/serial_host_model.sv
// host side serial master model for the register link
`timescale 1ns/1ps
`default_nettype none
module serial_host_model #(
    parameter int HALF_NS = 1303
) (
    // resolved data wire
    input wire logic sda_in,
    // clock and open drain data drive
    output logic scl_out,
    output logic sda_oe_out
);
    // clock stands high between frames
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end

    // half period keeps the rate under 400 kHz
    task automatic shift(input logic [7:0] b, output logic [7:0] q, output logic ack);
        logic [8:0] w;
        w = {b, 1'b1};
        q = 8'h00;
        for (int i = 8; i >= 0; i--) begin
            sda_oe_out = !w[i];
            #HALF_NS;
            scl_out = 1'b1;
            if (i > 0) begin
                q = {q[6:0], sda_in};
            end
            ack = !sda_in;
            #HALF_NS;
            scl_out = 1'b0;
        end
    endtask

    // start, address byte, one data byte, stop
    task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic ack,
                         output logic [7:0] q);
        logic a_ack;
        logic d_ack;
        logic [7:0] junk;
        sda_oe_out = 1'b1;
        #HALF_NS;
        scl_out = 1'b0;
        shift(a, junk, a_ack);
        // reads release the wire and end without acknowledge
        shift(a[0] ? 8'hFF : d, q, d_ack);
        sda_oe_out = 1'b1;
        #HALF_NS;
        scl_out = 1'b1;
        #HALF_NS;
        sda_oe_out = 1'b0;
        #HALF_NS;
        ack = a_ack && (a[0] || d_ack);
    endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the card slot host control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import card_slot_pkg::*;
    localparam int DEB = 20;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic aux_n = 1'b1;
    logic sdwn_n = 1'b1;
    logic asel = 1'b0;
    logic presence_slot1 = 1'b0;
    logic [2:0] sam = 3'h0;
    logic strap = 1'b0;
    logic presence_slot2 = 1'b0;
    logic heat = 1'b0;
    logic drop = 1'b0;
    slot_events_t ev = '0;
    logic scl, host_oe, sda_o, sda_oe, irq_n, ack;
    logic [4:0] act;
    logic [7:0] sp1, sp_sh, q, v;
    wire logic sda;
    int fail_count = 0;
    int total_checks = 0;
    int seed = 35589;

    // open drain wire with pull-up
    assign sda = !((sda_oe && !sda_o) || host_oe);
    always #25 clk_in = ~clk_in;

    serial_host_model host (.sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));

    card_slot_host_control #(.DEBOUNCE_CYCLES(DEB)) dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .address_select_pin_in(asel),
        .irq_out_n(irq_n), .aux_irq_in_n(aux_n), .shutdown_n_pin_in(sdwn_n),
        .presence_polarity_strap_in(strap), .presence_slot1_in(presence_slot1),
        .presence_slot2_in(presence_slot2), .sam_status_in(sam), .slot_events_in(ev),
        .overheat_in(heat), .supply_drop_in(drop), .slot_active_out(act),
        .slot1_edge_speed_out(sp1), .shared_edge_speed_out(sp_sh));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // expected slot status byte from its fields
    function automatic logic [7:0] st_exp(input logic slot_presence_bit, input logic [4:0] flags,
                                          input logic act);
        return {1'b0, act, flags, slot_presence_bit};
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // register access helpers, address acknowledge always expected
    task automatic rd(input logic [7:0] a);
        host.frame(a | 8'h01, 8'hFF, ack, q);
        @(negedge clk_in);
        check("ack", {7'h00, ack}, 8'h01);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] junk;
        host.frame(a, d, ack, junk);
        @(negedge clk_in);
        check("ack", {7'h00, ack}, 8'h01);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    // hang guard
    initial begin
        #4_000_000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        idle(10);
        reset_n_in = 1'b1;
        idle(10);
        // release after reset behaves as a shutdown exit
        check("irq", {7'h00, irq_n}, 8'h00);
        rd(8'h48);
        check("bank", q, 8'h00);
        rd(8'h40);
        check("general", q, 8'h1F);
        for (int s = 1; s <= 5; s++) begin
            wr(8'h48, 8'(s));
            rd(8'h48);
            check("bank", q, 8'(s));
            rd(8'h40);
            check("status", q, 8'h10);
            rd(8'h40);
            check("status", q, 8'h00);
        end
        idle(3);
        check("irq", {7'h00, irq_n}, 8'h01);
        // edge speed, slot 1 own and slot 2 shared
        for (int s = 1; s <= 2; s++) begin
            wr(8'h48, 8'(s));
            wr(8'h40, 8'h20);
            rd(8'h42);
            check("speed", q, EDGE_SPEED_RST);
            v = 8'($random(seed));
            wr(8'h42, v);
            rd(8'h42);
            check("speed", q, v);
            check("speed out", s == 1 ? sp1 : sp_sh, v);
        end
        check("shared", sp_sh, v);
        // auxiliary interrupt
        wr(8'h48, 8'h00);
        aux_n = 1'b0;
        idle(8);
        check("irq", {7'h00, irq_n}, 8'h00);
        rd(8'h40);
        check("general", q, 8'h20);
        aux_n = 1'b1;
        idle(8);
        check("irq", {7'h00, irq_n}, 8'h01);
        // status inputs of slots 3 to 5 copied only
        sam = 3'($random(seed));
        idle(4);
        for (int s = 3; s <= 5; s++) begin
            wr(8'h48, 8'(s));
            rd(8'h40);
            check("sam", q, {7'h00, sam[s-3]});
        end
        // short bounce must not confirm, long one must
        wr(8'h48, 8'h01);
        presence_slot1 = 1'b1;
        idle(DEB / 2);
        presence_slot1 = 1'b0;
        idle(4);
        rd(8'h40);
        check("bounce", q, 8'h00);
        presence_slot1 = 1'b1;
        idle(DEB + 10);
        check("irq", {7'h00, irq_n}, 8'h00);
        rd(8'h40);
        check("insert", q, 8'h21);
        presence_slot1 = 1'b0;
        idle(4);
        rd(8'h40);
        check("extract", q, 8'h20);
        // main write not readable; overload, overheat and supply drop kill slots
        wr(8'h40, 8'h01);
        rd(8'h40);
        check("status", q, st_exp(1'b0, 5'h00, 1'b1));
        wr(8'h48, 8'h02);
        wr(8'h40, 8'h01);
        check("active", {3'h0, act}, 8'h03);
        ev.overload = 5'h02;
        idle(1);
        ev = '0;
        idle(5);
        check("active", {3'h0, act}, 8'h01);
        heat = 1'b1;
        idle(1);
        heat = 1'b0;
        idle(5);
        check("active", {3'h0, act}, 8'h00);
        wr(8'h40, 8'h01);
        drop = 1'b1;
        ev.no_answer = 5'h02;
        idle(1);
        drop = 1'b0;
        ev = '0;
        idle(5);
        check("active", {3'h0, act}, 8'h00);
        rd(8'h40);
        check("status", q, st_exp(1'b0, 5'h0E, 1'b0));
        rd(8'h40);
        check("status", q, 8'h00);
        // slot 2 invert bit, then the strap flips slot 1 polarity
        wr(8'h40, 8'h08);
        idle(DEB + 10);
        rd(8'h40);
        check("invert", q, st_exp(1'b1, 5'h10, 1'b0));
        strap = 1'b1;
        presence_slot2 = 1'b1;
        idle(DEB + 10);
        wr(8'h48, 8'h01);
        rd(8'h40);
        check("strap", q, st_exp(1'b1, 5'h1C, 1'b0));
        // shutdown keeps slot 1 presence alive; exit reloads defaults
        sdwn_n = 1'b0;
        idle(6);
        check("irq", {7'h00, irq_n}, 8'h01);
        presence_slot1 = 1'b1;
        idle(6);
        check("irq", {7'h00, irq_n}, 8'h00);
        sdwn_n = 1'b1;
        idle(6);
        check("irq", {7'h00, irq_n}, 8'h00);
        rd(8'h48);
        check("bank", q, 8'h00);
        rd(8'h40);
        check("general", q, 8'h1F);
        check("speed out", sp1, EDGE_SPEED_RST);
        wr(8'h48, 8'h01);
        // address set follows the select pin
        host.frame(8'h4D, 8'hFF, ack, q);
        check("foreign ack", {7'h00, ack}, 8'h00);
        asel = 1'b1;
        idle(2);
        host.frame(8'h49, 8'hFF, ack, q);
        check("old ack", {7'h00, ack}, 8'h00);
        rd(8'h4C);
        check("bank", q, 8'h01);
        report_and_stop();
    end
endmodule
`default_nettype wire
